//--- rtl/ivpm_top.sv
// Interrupt vector and priority arbiter with APB register access
//
// Behaviour
// - Lower vector number wins under default priority
// - NMI vector 7 always top; others via registers
// - Default ordering after reset
// - 16-bit vector address, two or four bytes
// - Watchdog vector 20, register A bit 3
// - Timer 0 vectors 24-26, register A bit 2
// - Timer 1 vectors 28-30, register A bit 1
// - Timer 2 vectors 32-34, register A bit 0
// - Timer 3 vectors 36-38, register B bit 7
// - Timer 4 vectors 40-42, register B bit 6
// - Serial 0 vectors 52-55, register B bit 3
// - Serial 1 vectors 56-59, register B bit 2
// - Pins 0,1,4,5 vectors 12,13,16,17
// - Level 1 group beats all level 0
// - Equal levels resolved by vector order
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module ivpm_top (
	input  wire logic                  pclk,           // System clock, 50 MHz
	input  wire logic                  presetn,        // Asynchronous reset, active low
	input  wire logic                  psel,           // APB select
	input  wire logic                  penable,        // APB access phase
	input  wire logic                  pwrite,         // APB write
	input  wire logic [7:0]            paddr,          // APB byte address
	input  wire logic [31:0]           pwdata,         // APB write data
	output logic      [31:0]           prdata,         // APB read data
	output logic                       pready,         // APB ready
	output logic                       pslverr,        // APB error on unmapped address
	input  wire ivpm_pkg::ivpm_src_type src,           // Request levels from sources
	input  wire logic                  advanced_mode,  // Four-byte vector entries
	input  wire logic                  cpu_ack,        // CPU took the presented vector
	output ivpm_pkg::ivpm_win_type     win,            // Presented winning request
	output logic                       irq             // Unmasked event pending
);

	localparam int IW = $clog2(ivpm_pkg::VEC_SLOTS);

	// ****************************************
	// Request slots and group levels
	// ****************************************
	logic [ivpm_pkg::VEC_SLOTS-1:0] req_vec;
	logic [ivpm_pkg::VEC_SLOTS-1:0] lvl_vec;
	logic [ivpm_pkg::VEC_SLOTS-1:0] hi_vec;
	logic [7:0]                     prio_a_q;
	logic [7:0]                     prio_a_d;
	logic [7:0]                     prio_b_q;
	logic [7:0]                     prio_b_d;

	always_comb
	begin
		req_vec = '0;
		lvl_vec = '0;
		req_vec[ivpm_pkg::VEC_PIN0] = src.external_request_pin0;
		req_vec[ivpm_pkg::VEC_PIN1] = src.external_request_pin1;
		req_vec[ivpm_pkg::VEC_PIN4] = src.external_request_pin4;
		req_vec[ivpm_pkg::VEC_PIN5] = src.external_request_pin5;
		lvl_vec[ivpm_pkg::VEC_PIN0] = prio_a_q[ivpm_pkg::PRA_PIN0];
		lvl_vec[ivpm_pkg::VEC_PIN1] = prio_a_q[ivpm_pkg::PRA_PIN1];
		lvl_vec[ivpm_pkg::VEC_PIN4] = prio_a_q[ivpm_pkg::PRA_PIN45];
		lvl_vec[ivpm_pkg::VEC_PIN5] = prio_a_q[ivpm_pkg::PRA_PIN45];
		req_vec[ivpm_pkg::VEC_WATCHDOG] = src.watchdog_interval_overflow_req;
		lvl_vec[ivpm_pkg::VEC_WATCHDOG] = prio_a_q[ivpm_pkg::PRA_WATCHDOG];
		for (int c = 0; c < ivpm_pkg::TIMER_CHANNELS; c++)
		begin
			logic lv;
			lv = 1'b0;
			// Channels 0-2 use A bits 2..0, channels 3-4 use B bits 7..6
			if (c < 3)
				lv = prio_a_q[ivpm_pkg::PRA_TIMER0 - c];
			else
				lv = prio_b_q[ivpm_pkg::PRB_TIMER3 + 3 - c];
			req_vec[ivpm_pkg::VEC_TIMER_BASE + ivpm_pkg::VEC_TIMER_STEP*c]     = src.timer[c].match_capture_a_req;
			req_vec[ivpm_pkg::VEC_TIMER_BASE + ivpm_pkg::VEC_TIMER_STEP*c + 1] = src.timer[c].match_capture_b_req;
			req_vec[ivpm_pkg::VEC_TIMER_BASE + ivpm_pkg::VEC_TIMER_STEP*c + 2] = src.timer[c].overflow_req;
			for (int k = 0; k < 3; k++)
				lvl_vec[ivpm_pkg::VEC_TIMER_BASE + ivpm_pkg::VEC_TIMER_STEP*c + k] = lv;
		end
		for (int c = 0; c < ivpm_pkg::SERIAL_CHANNELS; c++)
		begin
			logic lv;
			lv = prio_b_q[ivpm_pkg::PRB_SERIAL0 - c];
			req_vec[ivpm_pkg::VEC_SERIAL_BASE + ivpm_pkg::VEC_SERIAL_STEP*c]     = src.serial[c].receive_error_req;
			req_vec[ivpm_pkg::VEC_SERIAL_BASE + ivpm_pkg::VEC_SERIAL_STEP*c + 1] = src.serial[c].receive_full_req;
			req_vec[ivpm_pkg::VEC_SERIAL_BASE + ivpm_pkg::VEC_SERIAL_STEP*c + 2] = src.serial[c].transmit_empty_req;
			req_vec[ivpm_pkg::VEC_SERIAL_BASE + ivpm_pkg::VEC_SERIAL_STEP*c + 3] = src.serial[c].transmit_end_req;
			for (int k = 0; k < 4; k++)
				lvl_vec[ivpm_pkg::VEC_SERIAL_BASE + ivpm_pkg::VEC_SERIAL_STEP*c + k] = lv;
		end
		req_vec[ivpm_pkg::VEC_CONVERTER] = src.converter_end_req;
		lvl_vec[ivpm_pkg::VEC_CONVERTER] = prio_b_q[ivpm_pkg::PRB_CONVERTER];
	end

	assign hi_vec = req_vec & lvl_vec;

	// ****************************************
	// Arbitration
	// ****************************************
	logic          hi_found;
	logic [IW-1:0] hi_index;
	logic          any_found;
	logic [IW-1:0] any_index;

	ivpm_first_set #(
		.WIDTH (ivpm_pkg::VEC_SLOTS)
	) u_first_hi (
		.req_i   (hi_vec),
		.found_o (hi_found),
		.index_o (hi_index)
	);

	ivpm_first_set #(
		.WIDTH (ivpm_pkg::VEC_SLOTS)
	) u_first_any (
		.req_i   (req_vec),
		.found_o (any_found),
		.index_o (any_index)
	);

	ivpm_pkg::ivpm_win_type win_q;
	ivpm_pkg::ivpm_win_type win_d;

	always_comb
	begin
		logic [7:0] v;
		v = 8'h00;
		win_d = '0;
		if (src.nmi_req)
		begin
			v = 8'(ivpm_pkg::VEC_NMI);
			win_d.level = 1'b1;
		end
		else if (hi_found)
		begin
			v = 8'(hi_index);
			win_d.level = 1'b1;
		end
		else if (any_found)
		begin
			v = 8'(any_index);
		end
		win_d.valid = src.nmi_req | any_found;
		win_d.vector = v;
		if (advanced_mode)
			win_d.address = 16'(v) << ivpm_pkg::ADDR_SHIFT_ADVANCED;
		else
			win_d.address = 16'(v) << ivpm_pkg::ADDR_SHIFT_NORMAL;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			win_q <= '0;
		else
			win_q <= win_d;
	end

	assign win = win_q;

	// ****************************************
	// APB registers and event status
	// ****************************************
	logic                          wr_en;
	logic                          rd_en;
	logic [ivpm_pkg::EVT_COUNT-1:0] stat_q;
	logic [ivpm_pkg::EVT_COUNT-1:0] stat_d;
	logic [ivpm_pkg::EVT_COUNT-1:0] mask_q;
	logic [ivpm_pkg::EVT_COUNT-1:0] mask_d;
	logic [ivpm_pkg::EVT_COUNT-1:0] evt;
	logic                          nmi_q;
	logic                          live_q;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign pready = 1'b1;

	always_comb
	begin
		evt = '0;
		evt[ivpm_pkg::EVT_NMI] = src.nmi_req & ~nmi_q;
		evt[ivpm_pkg::EVT_NEW_WIN] = win_d.valid & (~win_q.valid | (win_d.vector != win_q.vector));
		evt[ivpm_pkg::EVT_ACK] = cpu_ack;
		prio_a_d = prio_a_q;
		prio_b_d = prio_b_q;
		mask_d = mask_q;
		stat_d = stat_q;
		if (wr_en && paddr == ivpm_pkg::OFS_PRIO_A)
			prio_a_d = pwdata[7:0];
		if (wr_en && paddr == ivpm_pkg::OFS_PRIO_B)
			prio_b_d = pwdata[7:0];
		if (wr_en && paddr == ivpm_pkg::OFS_MASK)
			mask_d = pwdata[ivpm_pkg::EVT_COUNT-1:0];
		if (rd_en && paddr == ivpm_pkg::OFS_STATUS)
			stat_d = '0;
		// A new event in the clearing cycle survives
		stat_d = stat_d | evt;
		prdata = 32'h0000_0000;
		pslverr = 1'b0;
		case (paddr)
			ivpm_pkg::OFS_PRIO_A: prdata[7:0] = prio_a_q;
			ivpm_pkg::OFS_PRIO_B: prdata[7:0] = prio_b_q;
			ivpm_pkg::OFS_STATUS: prdata[ivpm_pkg::EVT_COUNT-1:0] = stat_q;
			ivpm_pkg::OFS_MASK:   prdata[ivpm_pkg::EVT_COUNT-1:0] = mask_q;
			ivpm_pkg::OFS_WINNER:
			begin
				prdata[7:0] = win_q.vector;
				prdata[ivpm_pkg::WIN_LEVEL_BIT] = win_q.level;
				prdata[ivpm_pkg::WIN_VALID_BIT] = win_q.valid;
				prdata[ivpm_pkg::WIN_ADDR_LSB +: 16] = win_q.address;
			end
			default: pslverr = psel & penable;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prio_a_q <= ivpm_pkg::RST_PRIO;
			prio_b_q <= ivpm_pkg::RST_PRIO;
			stat_q <= ivpm_pkg::RST_EVENTS;
			mask_q <= ivpm_pkg::RST_EVENTS;
			nmi_q <= 1'b0;
			live_q <= 1'b0;
		end
		else
		begin
			prio_a_q <= prio_a_d;
			prio_b_q <= prio_b_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			nmi_q <= src.nmi_req;
			live_q <= 1'b1;
		end
	end

	assign irq = |(stat_q & mask_q);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	// Skip the release edge: the flops still see reset there
	default disable iff (!presetn || !live_q);

	function automatic logic [ivpm_pkg::VEC_SLOTS-1:0] below(input logic [7:0] v);
		below = (64'h0000_0000_0000_0001 << v) - 64'h0000_0000_0000_0001;
	endfunction

	function automatic logic listed(input logic [7:0] v);
		listed = (v == 8'd7) || (v == 8'd12) || (v == 8'd13) || (v == 8'd16) || (v == 8'd17)
			|| (v == 8'd20) || (v == 8'd60) || (v >= 8'd52 && v <= 8'd59)
			|| (v >= 8'd24 && v <= 8'd42 && v[1:0] != 2'b11);
	endfunction

	property only_p(logic s, int v, logic lv);
		s && !src.nmi_req && $onehot(req_vec) |=> win_q.valid && win_q.vector == 8'(v) && win_q.level == $past(lv);
	endproperty

	sequence two_level_s;
		!src.nmi_req && (|hi_vec) && (|(req_vec & ~lvl_vec));
	endsequence

	nmi_top_a: assert property (src.nmi_req |=> win_q.vector == 8'd7 && win_q.level)
		else $error("NMI request did not win");
	default_order_a: assert property (!src.nmi_req && !(|hi_vec) && (|req_vec)
		|=> !(|($past(req_vec) & below(win_q.vector))))
		else $error("Lower pending vector lost under default order");
	equal_level_a: assert property (!src.nmi_req && (|hi_vec)
		|=> !(|($past(hi_vec) & below(win_q.vector))))
		else $error("Lower vector lost among level 1 requests");
	level_one_a: assert property (two_level_s |=> win_q.level
		&& (|($past(hi_vec) & (64'h0000_0000_0000_0001 << win_q.vector))))
		else $error("Level 0 request beat a level 1 request");
	reset_default_a: assert property ($rose(presetn) |-> prio_a_q == 8'h00 && prio_b_q == 8'h00)
		else $error("Priority registers not cleared by reset");
	prio_write_a: assert property (wr_en && paddr == ivpm_pkg::OFS_PRIO_A |=> prio_a_q == $past(pwdata[7:0]))
		else $error("Priority register A write lost");
	addr_form_a: assert property (##1 win_q.valid |-> win_q.address
		== (16'(win_q.vector) << ($past(advanced_mode) ? 2 : 1)))
		else $error("Vector address malformed");
	no_reserved_a: assert property (win_q.valid |-> listed(win_q.vector))
		else $error("Reserved vector issued");
	idle_a: assert property (!src.nmi_req && !(|req_vec) |=> !win_q.valid)
		else $error("Winner presented without request");
	watchdog_a: assert property (only_p(src.watchdog_interval_overflow_req, 20, prio_a_q[3]))
		else $error("Watchdog vector wrong");
	timer0_a: assert property (only_p(src.timer[0].overflow_req, 26, prio_a_q[2]))
		else $error("Timer 0 vector wrong");
	timer1_a: assert property (only_p(src.timer[1].match_capture_b_req, 29, prio_a_q[1]))
		else $error("Timer 1 vector wrong");
	timer2_a: assert property (only_p(src.timer[2].match_capture_a_req, 32, prio_a_q[0]))
		else $error("Timer 2 vector wrong");
	timer3_a: assert property (only_p(src.timer[3].overflow_req, 38, prio_b_q[7]))
		else $error("Timer 3 vector wrong");
	timer4_a: assert property (only_p(src.timer[4].match_capture_a_req, 40, prio_b_q[6]))
		else $error("Timer 4 vector wrong");
	serial0_a: assert property (only_p(src.serial[0].transmit_end_req, 55, prio_b_q[3]))
		else $error("Serial 0 vector wrong");
	serial1_a: assert property (only_p(src.serial[1].receive_error_req, 56, prio_b_q[2]))
		else $error("Serial 1 vector wrong");
	pin5_a: assert property (only_p(src.external_request_pin5, 17, prio_a_q[4]))
		else $error("Pin 5 vector wrong");
	pin0_a: assert property (only_p(src.external_request_pin0, 12, prio_a_q[7]))
		else $error("Pin 0 vector wrong");
	converter_a: assert property (only_p(src.converter_end_req, 60, prio_b_q[1]))
		else $error("Converter vector wrong");
	stat_hold_a: assert property (evt[ivpm_pkg::EVT_ACK] |=> stat_q[ivpm_pkg::EVT_ACK])
		else $error("Acknowledge event lost");

endmodule

//--- rtl/ivpm_pkg.sv
// Package of vector numbers, priority bit positions, register map and carrier types
package ivpm_pkg;

	// ****************************************
	// Vector numbers
	// ****************************************
	localparam int VEC_SLOTS      = 64;
	localparam int VEC_NMI        = 7;
	localparam int VEC_PIN0       = 12;
	localparam int VEC_PIN1       = 13;
	localparam int VEC_PIN4       = 16;
	localparam int VEC_PIN5       = 17;
	localparam int VEC_WATCHDOG   = 20;
	localparam int VEC_TIMER_BASE = 24;
	localparam int VEC_TIMER_STEP = 4;
	localparam int VEC_SERIAL_BASE = 52;
	localparam int VEC_SERIAL_STEP = 4;
	localparam int VEC_CONVERTER  = 60;
	localparam int TIMER_CHANNELS = 5;
	localparam int SERIAL_CHANNELS = 2;

	// ****************************************
	// Group priority bit positions
	// ****************************************
	localparam int PRA_PIN0      = 7;
	localparam int PRA_PIN1      = 6;
	localparam int PRA_PIN45     = 4;
	localparam int PRA_WATCHDOG  = 3;
	localparam int PRA_TIMER0    = 2;
	localparam int PRB_TIMER3    = 7;
	localparam int PRB_SERIAL0   = 3;
	localparam int PRB_CONVERTER = 1;

	// ****************************************
	// Register map and reset values
	// ****************************************
	localparam logic [7:0]  OFS_PRIO_A   = 8'h00;
	localparam logic [7:0]  OFS_PRIO_B   = 8'h04;
	localparam logic [7:0]  OFS_STATUS   = 8'h08;
	localparam logic [7:0]  OFS_MASK     = 8'h0C;
	localparam logic [7:0]  OFS_WINNER   = 8'h10;
	localparam logic [7:0]  RST_PRIO     = 8'h00;
	localparam logic [2:0]  RST_EVENTS   = 3'h0;
	localparam int          EVT_NMI      = 0;
	localparam int          EVT_NEW_WIN  = 1;
	localparam int          EVT_ACK      = 2;
	localparam int          EVT_COUNT    = 3;
	localparam int          WIN_LEVEL_BIT = 8;
	localparam int          WIN_VALID_BIT = 9;
	localparam int          WIN_ADDR_LSB = 16;
	localparam int          ADDR_SHIFT_NORMAL = 1;
	localparam int          ADDR_SHIFT_ADVANCED = 2;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic match_capture_a_req;
		logic match_capture_b_req;
		logic overflow_req;
	} ivpm_timer_type;

	typedef struct packed {
		logic receive_error_req;
		logic receive_full_req;
		logic transmit_empty_req;
		logic transmit_end_req;
	} ivpm_serial_type;

	typedef struct packed {
		logic                                    nmi_req;
		logic                                    external_request_pin0;
		logic                                    external_request_pin1;
		logic                                    external_request_pin4;
		logic                                    external_request_pin5;
		logic                                    watchdog_interval_overflow_req;
		ivpm_timer_type  [TIMER_CHANNELS-1:0]    timer;
		ivpm_serial_type [SERIAL_CHANNELS-1:0]   serial;
		logic                                    converter_end_req;
	} ivpm_src_type;

	typedef struct packed {
		logic        valid;
		logic        level;
		logic [7:0]  vector;
		logic [15:0] address;
	} ivpm_win_type;

endpackage

//--- rtl/ivpm_first_set.sv
// Finds the lowest set bit of a request vector
`timescale 1ns/100ps
module ivpm_first_set #(
	parameter int WIDTH = 64
) (
	input  wire logic [WIDTH-1:0]         req_i,   // Request bits, bit 0 ranks first
	output logic                          found_o, // Any bit set
	output logic [$clog2(WIDTH)-1:0]      index_o  // Lowest set bit
);

	// Refuse a width that leaves no index bits
	if (WIDTH < 2)
	begin
		$error("ivpm_first_set: WIDTH must be at least 2");
	end

	always_comb
	begin
		found_o = 1'b0;
		index_o = '0;
		for (int i = WIDTH - 1; i >= 0; i--)
		begin
			if (req_i[i])
			begin
				found_o = 1'b1;
				index_o = ($clog2(WIDTH))'(i);
			end
		end
	end

endmodule

//--- bench/ivpm_cpu_model.sv
// CPU core model that fetches a newly presented vector when it is not already waiting, and acknowledges it
`timescale 1ns/100ps
module ivpm_cpu_model (
	input  wire logic                   pclk,    // System clock
	input  wire logic                   presetn, // Reset, active low
	input  wire ivpm_pkg::ivpm_win_type win,     // Presented request
	input  wire logic                   slow,    // Four-cycle exception entry
	output logic                        cpu_ack  // One-cycle vector fetch pulse
);
	logic [7:0] taken_q;
	logic [2:0] wait_q;

	// Acknowledge once per new vector seen while not waiting, promptly or slowly
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cpu_ack <= 1'b0;
			taken_q <= 8'h00;
			wait_q  <= 3'h0;
		end
		else
		begin
			cpu_ack <= (wait_q == 3'h1);
			if (wait_q != 3'h0)
				wait_q <= wait_q - 3'h1;
			else if (!win.valid)
				taken_q <= 8'h00;
			else if (win.vector != taken_q)
			begin
				taken_q <= win.vector;
				wait_q  <= slow ? 3'h4 : 3'h1;
			end
		end
	end
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the vector and priority arbiter
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
	typedef struct { logic chk; logic err; logic [31:0] data; } ivpm_rd_type;
	typedef struct { logic kind; ivpm_pkg::ivpm_win_type w; logic irq; } ivpm_out_type;

	logic                   pclk = 1'b0;
	logic                   presetn = 1'b0;
	logic                   psel = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite = 1'b0;
	logic [7:0]             paddr = 8'h00;
	logic [31:0]            pwdata = 32'h0000_0000;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	ivpm_pkg::ivpm_src_type src = '0;
	logic                   adv = 1'b0;
	logic                   slow = 1'b0;
	logic                   cpu_ack;
	ivpm_pkg::ivpm_win_type win;
	logic                   irq;
	logic                   due = 1'b0;
	logic [7:0]             pa = 8'h00;
	logic [7:0]             pb = 8'h00;
	logic [7:0]             addrs [6] = '{ivpm_pkg::OFS_PRIO_A, ivpm_pkg::OFS_PRIO_B, ivpm_pkg::OFS_STATUS,
		ivpm_pkg::OFS_MASK, ivpm_pkg::OFS_WINNER, 8'h14};
	int                     mismatches = 0;
	int                     n_tests = 0;
	int                     cycles = 0;
	int                     seed = 32'h1430_95b3;
	ivpm_rd_type            rd_q[$];
	ivpm_out_type           out_q[$];
	ivpm_rd_type            rd_e;
	ivpm_out_type           out_e;

	always #10 pclk = ~pclk;

	ivpm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
		.advanced_mode(adv), .cpu_ack(cpu_ack), .win(win), .irq(irq));

	ivpm_cpu_model cpu (.pclk(pclk), .presetn(presetn), .win(win), .slow(slow), .cpu_ack(cpu_ack));

	// ********
	// Reference arbitration
	// ********
	function automatic int vec_of(int i);
		if (i == 0) return 60;
		if (i <= 8) return 52 + 4 * ((i - 1) / 4) + 3 - (i - 1) % 4;
		if (i <= 23) return 24 + 4 * ((i - 9) / 3) + 2 - (i - 9) % 3;
		return (i == 24) ? 20 : (i == 25) ? 17 : (i == 26) ? 16 : (i == 27) ? 13 : (i == 28) ? 12 : 7;
	endfunction

	function automatic logic lvl_of(int i);
		logic [15:0] p;
		int          pos [5] = '{10, 9, 8, 7, 6};
		p = {pa, pb};
		if (i == 29) return 1'b1;
		if (i == 0) return p[1];
		if (i <= 8) return p[(i <= 4) ? 3 : 2];
		if (i <= 23) return p[pos[(i - 9) / 3]];
		return p[(i == 24) ? 11 : (i <= 26) ? 12 : (i == 27) ? 14 : 15];
	endfunction

	function automatic ivpm_pkg::ivpm_win_type ref_win(logic [29:0] s, logic m);
		ivpm_pkg::ivpm_win_type w;
		int                     best;
		int                     key;
		w = '0;
		best = -1;
		for (int i = 0; i < 30; i++)
			if (s[i])
			begin
				key = (i == 29) ? 1000 : lvl_of(i) * 64 + 63 - vec_of(i);
				if (key > best)
				begin
					best = key;
					w.valid = 1'b1;
					w.level = lvl_of(i);
					w.vector = 8'(vec_of(i));
					w.address = 16'(vec_of(i) << (m ? 2 : 1));
				end
			end
		return w;
	endfunction

	// ********
	// Drivers
	// ********
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic chk, logic err, logic [31:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr) rd_q.push_back('{chk, err, e});
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, 1'b1, a == 8'h14, e);
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d, 1'b0, 1'b0, 32'h0000_0000);
	endtask

	task automatic set_prio(logic [7:0] a, logic [7:0] b);
		wr(ivpm_pkg::OFS_PRIO_A, {24'h00_0000, a});
		wr(ivpm_pkg::OFS_PRIO_B, {24'h00_0000, b});
		pa = a;
		pb = b;
	endtask

	task automatic expect_out(ivpm_out_type o);
		out_q.push_back(o);
		@(posedge pclk);
		due <= 1'b1;
		@(posedge pclk);
		due <= 1'b0;
	endtask

	task automatic drive(logic [29:0] s, logic m);
		@(posedge pclk);
		src <= ivpm_pkg::ivpm_src_type'(s);
		adv <= m;
		expect_out('{1'b0, ref_win(s, m), 1'b0});
	endtask

	task automatic check_irq(logic v);
		expect_out('{1'b1, '0, v});
	endtask

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		pa = 8'h00;
		pb = 8'h00;
	endtask

	task automatic close_out();
		if (mismatches == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ********
	// Result watcher and timeout
	// ********
	always @(posedge pclk)
	begin
		if (psel && penable)
			`CHK("pready", 1'b1, pready)
		if (psel && penable && pready && !pwrite && rd_q.size() > 0)
		begin
			rd_e = rd_q.pop_front();
			if (rd_e.chk)
			begin
				`CHK("prdata", rd_e.data, prdata)
				`CHK("pslverr", rd_e.err, pslverr)
			end
		end
		if (due)
		begin
			out_e = out_q.pop_front();
			if (out_e.kind)
				`CHK("irq", out_e.irq, irq)
			else
			begin
				`CHK("win_valid", out_e.w.valid, win.valid)
				if (out_e.w.valid)
				begin
					`CHK("win_vector", out_e.w.vector, win.vector)
					`CHK("win_level", out_e.w.level, win.level)
					`CHK("win_address", out_e.w.address, win.address)
				end
			end
		end
	end

	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			mismatches++;
			close_out();
		end
	end

	// ********
	// Scenarios
	// ********
	initial
	begin
		do_reset();
		foreach (addrs[k]) rd(addrs[k], 32'h0000_0000);
		wr(ivpm_pkg::OFS_STATUS, 32'h0000_0007);
		wr(ivpm_pkg::OFS_WINNER, 32'hFFFF_FFFF);
		wr(8'h14, 32'hFFFF_FFFF);
		foreach (addrs[k]) rd(addrs[k], 32'h0000_0000);
		drive(30'h1FFF_FFFF, 1'b0);
		set_prio(8'h5A, 8'hC3);
		rd(ivpm_pkg::OFS_PRIO_A, 32'h0000_005A);
		rd(ivpm_pkg::OFS_PRIO_B, 32'h0000_00C3);
		// Each source alone, both entry sizes
		set_prio(8'h00, 8'h00);
		for (int m = 0; m < 2; m++)
			for (int i = 0; i < 30; i++)
				drive(30'h1 << i, m[0]);
		// One group bit raised at a time, unused bits included
		for (int p = 0; p < 16; p++)
		begin
			set_prio(p >= 8 ? 8'h1 << (p - 8) : 8'h0, p < 8 ? 8'h1 << p : 8'h0);
			drive(30'h1FFF_FFFF, 1'($random(seed)));
		end
		// Random request mixes, priorities and CPU pace
		repeat (150)
		begin
			set_prio(8'($random(seed)), 8'($random(seed)));
			slow <= 1'($random(seed));
			drive(30'($random(seed) & $random(seed)), 1'($random(seed)));
		end
		// Sticky status, mask and interrupt line
		drive(30'h0, 1'b0);
		repeat (8) @(posedge pclk);
		apb(1'b0, ivpm_pkg::OFS_STATUS, 32'h0000_0000, 1'b0, 1'b0, 32'h0000_0000);
		wr(ivpm_pkg::OFS_MASK, 32'h0000_0007);
		rd(ivpm_pkg::OFS_STATUS, 32'h0000_0000);
		check_irq(1'b0);
		drive(30'h1 << 29, 1'b0);
		repeat (8) @(posedge pclk);
		check_irq(1'b1);
		rd(ivpm_pkg::OFS_STATUS, 32'h0000_0007);
		rd(ivpm_pkg::OFS_STATUS, 32'h0000_0000);
		check_irq(1'b0);
		wr(ivpm_pkg::OFS_MASK, 32'h0000_0000);
		drive(30'h200, 1'b1);
		repeat (8) @(posedge pclk);
		check_irq(1'b0);
		wr(ivpm_pkg::OFS_MASK, 32'h0000_0002);
		check_irq(1'b1);
		rd(ivpm_pkg::OFS_STATUS, 32'h0000_0006);
		rd(ivpm_pkg::OFS_WINNER, {16'h0068, 6'h00, 1'b1, pa[2], 8'h1A});
		check_irq(1'b0);
		// Second reset in mid-run returns to default order
		do_reset();
		rd(ivpm_pkg::OFS_PRIO_A, 32'h0000_0000);
		drive(30'h1FFF_FFFF, 1'b0);
		close_out();
	end
endmodule
